// file: swar_pkg.sv
// swar_pkg: constants for the two-channel auto-retry and diagnostic logic
// assumes one 125 MHz core clock; register map is local to this block
package swar_pkg;
  // ----------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_RETRY0  = 4'h0; // retry control, channel 0
  localparam logic [3:0] ADDR_RETRY1  = 4'h1; // retry control, channel 1
  localparam logic [3:0] ADDR_CONFIG0 = 4'h2; // diag config, channel 0
  localparam logic [3:0] ADDR_CONFIG1 = 4'h3; // diag config, channel 1
  localparam logic [3:0] ADDR_FAULT0  = 4'h4; // fault register, channel 0
  localparam logic [3:0] ADDR_FAULT1  = 4'h5; // fault register, channel 1
  localparam logic [3:0] ADDR_STATUS  = 4'h6; // status register
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RET_SEL_BIT   = 0;  // retry select
  localparam int RET_UNLIM_BIT = 1;  // unlimited retries
  localparam int RET_PER_LO    = 2;  // retry period field D3:D2
  localparam int OD_CNT_LO     = 4;  // counter in OD7..OD4
  localparam int CFG_OS_DIS    = 6;
  localparam int CFG_OLOFF_DIS = 7;
  localparam int CFG_OPEN_LOAD_ON_FAULT_DIS  = 8;
  localparam int FLT_OC  = 0;
  localparam int FLT_SC  = 1;
  localparam int FLT_OT  = 2;
  localparam int FLT_UV  = 3;
  localparam int FLT_OPEN_LOAD_ON_FAULT  = 4;
  localparam int FLT_OLOFF = 5;
  localparam int FLT_OS    = 6;
  localparam int FLT_LATCH = 7;
  localparam int ST_RFULL0 = 4;
  localparam int ST_RFULL1 = 5;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RETRY_RST  = 16'h0000;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [3:0]  CNT_MAX    = 4'hf;   // 15 retries
  // duty limits in percent for the on-state open-load window
  localparam logic [6:0] DUTY_LIM_NORM = 7'h5a; // 90
  localparam logic [6:0] DUTY_LIM_OPEN_LOAD_ON_FAULT = 7'h55; // 85
  // ----------------------------------------------------------------
  // retry periods: four selectable times in microseconds
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 125;
  localparam int T_AUTO0_US  = 150;
  localparam int T_AUTO1_US  = 300;
  localparam int T_AUTO2_US  = 600;
  localparam int T_AUTO3_US  = 1200;
  localparam int CYC_AUTO0   = T_AUTO0_US * CLK_MHZ;
  localparam int CYC_AUTO1   = T_AUTO1_US * CLK_MHZ;
  localparam int CYC_AUTO2   = T_AUTO2_US * CLK_MHZ;
  localparam int CYC_AUTO3   = T_AUTO3_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_NORMAL, ST_WAIT, ST_LATCHED} swar_state_t;
endpackage

// file: swar_top.sv
// swar_top: auto-retry and diagnostic fault latching for two channels
// assumes inputs synchronous to core_clk; sensing done elsewhere
//
// Function
// - retry eligible only on overcurrent, severe short, overtemp or undervoltage
// - undervoltage or overtemp retries start only after cause has gone
// - with retry disabled a latchable fault latches at once
// - retry enabled when select bit D0 equals the application-type pin
// - retry starts when fault control is 1 and retry condition holds
// - channel turns on again after the period chosen by D3:D2
// - cause gone before exhaustion: normal run, counter and fault bit kept
// - unlimited mode with retry enabled retries forever and never latches
// - limited mode counts to 15 then sets the channel retry-full flag
// - after full one more retry; persisting overcurrent or severe short latches, fault low
// - host delatch turns channel on, counter is not cleared
// - counter reads in OD7..OD4 only in normal mode
// - counter cleared on fail-safe, wake, reset, unlimited set, disable
// - unlimited set while latched delatches; retry enabled: retries after one period, retry disabled: normal at once
// - lamp profile clears overcurrent duration counter at every retry
// - motor mode clears it at turn-off of first clean period
// - diagnostic faults set bits, never turn off; each has a disable bit
// - direct input low-sense with on open-load: duty limit 85, not 90
// - off-state short to supply sets bit and shows live on fault output
// - short to supply bit stays until fault register is read
// - off open-load checked every off period, either sense ratio
// - off open-load gone: fault output high at once, bit kept till read
`timescale 1ns/1ps
`default_nettype none
module swar_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // device mode
  input  wire logic        normal_mode,
  input  wire logic        failsafe_enter,
  input  wire logic        sleep_exit,
  input  wire logic        undervoltage_fault,
  // per-channel sensed conditions
  input  wire logic [1:0]  application_type_pin,
  input  wire logic [1:0]  fault_control_signal,
  input  wire logic [1:0]  overcurrent_fault,
  input  wire logic [1:0]  severe_short_fault,
  input  wire logic [1:0]  overtemp_fault,
  input  wire logic [1:0]  open_load_on_fault,
  input  wire logic [1:0]  open_load_off_fault,
  input  wire logic [1:0]  short_to_supply_fault,
  input  wire logic [1:0]  channel_cmd_on,
  input  wire logic [1:0]  delatch_req,
  input  wire logic [1:0]  period_end,
  input  wire logic [1:0]  direct_input,
  input  wire logic [1:0]  low_current_sense_ratio,
  input  wire logic [6:0]  duty_pct,
  // outputs
  output logic      [1:0]  channel_on,
  output logic      [1:0]  oc_dur_clear,
  output logic      [1:0]  diag_active,
  output logic             fault_out_n
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0]       retry_r  [2];
  logic [15:0]       config_r [2];
  logic [7:0]        fault_r  [2];
  logic [3:0]        cnt_r    [2];
  logic [1:0]        rfull_r;
  swar_pkg::swar_state_t state_r [2];
  logic [17:0]       tmr_r    [2];
  logic [1:0]        sel_q_r;
  logic [1:0]        oc_seen_r;
  logic [1:0]        on_q_r;
  logic [1:0]        ch_live_w;
  logic              por_r;
  // ----------------------------------------------------------------
  // per-channel combinational terms
  // ----------------------------------------------------------------
  logic [1:0] ret_en_w, unlim_w, cond_w, slow_w, start_w, lim_w;
  logic [1:0] clr_cnt_w, unl_rise_w, dis_ev_w, tmr_done_w;
  logic [1:0] os_det_w, open_load_on_fault_det_w, oloff_det_w, rd_flt_w, live_w;
  logic [17:0] per_w [2];
  logic [6:0]  duty_lim_w [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      // enable when select equals application type
      assign ret_en_w[g] = retry_r[g][swar_pkg::RET_SEL_BIT] ==
                           application_type_pin[g];
      assign unlim_w[g]  = retry_r[g][swar_pkg::RET_UNLIM_BIT];
      // only latchable faults count
      assign cond_w[g] = overcurrent_fault[g] | severe_short_fault[g] |
                         overtemp_fault[g] | undervoltage_fault;
      // slow faults must clear before the retry wait starts
      assign slow_w[g] = overtemp_fault[g] | undervoltage_fault;
      assign start_w[g] = fault_control_signal[g] & cond_w[g];
      assign lim_w[g]   = rfull_r[g] & ~unlim_w[g];
      // disable edge depends on type
      assign dis_ev_w[g] = application_type_pin[g] ?
                           (sel_q_r[g] & ~retry_r[g][0]) :
                           (~sel_q_r[g] & retry_r[g][0]);
      assign unl_rise_w[g] = reg_wr &&
        reg_addr == (g == 0 ? swar_pkg::ADDR_RETRY0 : swar_pkg::ADDR_RETRY1)
        && reg_wdata[swar_pkg::RET_UNLIM_BIT] && !unlim_w[g];
      assign clr_cnt_w[g] = failsafe_enter | sleep_exit | por_r |
                            unl_rise_w[g] | dis_ev_w[g];
      // period select from D3:D2
      assign per_w[g] =
        retry_r[g][3:2] == 2'h0 ? 18'(swar_pkg::CYC_AUTO0) :
        retry_r[g][3:2] == 2'h1 ? 18'(swar_pkg::CYC_AUTO1) :
        retry_r[g][3:2] == 2'h2 ? 18'(swar_pkg::CYC_AUTO2) :
                                  18'(swar_pkg::CYC_AUTO3);
      assign tmr_done_w[g] = tmr_r[g] >= per_w[g] - 18'h00001;
      // diagnostics gated by their own disable bits
      assign os_det_w[g] = short_to_supply_fault[g] & ~on_q_r[g] &
                           ~config_r[g][swar_pkg::CFG_OS_DIS];
      assign oloff_det_w[g] = open_load_off_fault[g] & ~on_q_r[g] &
                           ~config_r[g][swar_pkg::CFG_OLOFF_DIS];
      assign open_load_on_fault_det_w[g] = open_load_on_fault[g] & on_q_r[g] &
                           ~config_r[g][swar_pkg::CFG_OPEN_LOAD_ON_FAULT_DIS];
      assign rd_flt_w[g] = reg_rd && reg_addr ==
        (g == 0 ? swar_pkg::ADDR_FAULT0 : swar_pkg::ADDR_FAULT1);
      // live fault: latched, or diagnostic present now
      assign live_w[g] = state_r[g] == swar_pkg::ST_LATCHED | os_det_w[g] |
                         oloff_det_w[g] | open_load_on_fault_det_w[g];
      assign ch_live_w[g] = channel_cmd_on[g] &
                            state_r[g] == swar_pkg::ST_NORMAL;
      // on-state open-load check narrows the window
      assign duty_lim_w[g] = (direct_input[g] & low_current_sense_ratio[g] &
        ~config_r[g][swar_pkg::CFG_OPEN_LOAD_ON_FAULT_DIS]) ? swar_pkg::DUTY_LIM_OPEN_LOAD_ON_FAULT :
        swar_pkg::DUTY_LIM_NORM;
    end
  endgenerate
  // ----------------------------------------------------------------
  // reset-pulse helper: counter clear on power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_r <= 1'b1;
    end else if (clk_en) begin
      por_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // configuration registers; counter-clearing side effects above
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      retry_r[0]  <= swar_pkg::RETRY_RST;
      retry_r[1]  <= swar_pkg::RETRY_RST;
      config_r[0] <= swar_pkg::CONFIG_RST;
      config_r[1] <= swar_pkg::CONFIG_RST;
      sel_q_r     <= 2'h0;
    end else if (clk_en) begin
      sel_q_r <= {retry_r[1][0], retry_r[0][0]};
      if (reg_wr && reg_addr == swar_pkg::ADDR_RETRY0) begin
        retry_r[0] <= {12'h000, reg_wdata[3:0]};
      end else if (reg_wr && reg_addr == swar_pkg::ADDR_RETRY1) begin
        retry_r[1] <= {12'h000, reg_wdata[3:0]};
      end else if (reg_wr && reg_addr == swar_pkg::ADDR_CONFIG0) begin
        config_r[0] <= {7'h00, reg_wdata[8:6], 6'h00};
      end else if (reg_wr && reg_addr == swar_pkg::ADDR_CONFIG1) begin
        config_r[1] <= {7'h00, reg_wdata[8:6], 6'h00};
      end
    end
  end
  // ----------------------------------------------------------------
  // retry state machine, counter and timer per channel
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : g_fsm
      always_ff @(posedge core_clk) begin
        if (rst) begin
          state_r[g]   <= swar_pkg::ST_NORMAL;
          cnt_r[g]     <= 4'h0;
          rfull_r[g]   <= 1'b0;
          tmr_r[g]     <= 18'h00000;
          oc_seen_r[g] <= 1'b0;
          on_q_r[g]    <= 1'b0;
          oc_dur_clear[g] <= 1'b0;
        end else if (clk_en) begin
          oc_dur_clear[g] <= 1'b0;
          on_q_r[g] <= ch_live_w[g];
          if (overcurrent_fault[g]) begin
            oc_seen_r[g] <= 1'b1;
          end
          // motor: clear duration at first clean turn-off
          if (application_type_pin[g] && on_q_r[g] && !ch_live_w[g]) begin
            if (!oc_seen_r[g] && !overcurrent_fault[g]) begin
              oc_dur_clear[g] <= 1'b1;
            end
            oc_seen_r[g] <= 1'b0;
          end
          case (state_r[g])
            swar_pkg::ST_NORMAL: begin
              tmr_r[g] <= 18'h00000;
              if (cond_w[g] && !ret_en_w[g]) begin
                state_r[g] <= swar_pkg::ST_LATCHED;
              end else if (start_w[g]) begin
                state_r[g] <= swar_pkg::ST_WAIT;
              end
            end
            swar_pkg::ST_WAIT: begin
              if (delatch_req[g]) begin
                state_r[g] <= swar_pkg::ST_NORMAL;
              end else if (!ret_en_w[g]) begin
                state_r[g] <= swar_pkg::ST_LATCHED;
              end else if (slow_w[g]) begin
                tmr_r[g] <= 18'h00000;
              end else if (!tmr_done_w[g]) begin
                tmr_r[g] <= tmr_r[g] + 18'h00001;
              end else if (lim_w[g] && cnt_r[g] == swar_pkg::CNT_MAX &&
                           start_w[g] && cond_w[g] &&
                           (overcurrent_fault[g] | severe_short_fault[g])) begin
                state_r[g] <= swar_pkg::ST_LATCHED;
              end else begin
                state_r[g] <= swar_pkg::ST_NORMAL;
                if (!application_type_pin[g]) begin
                  oc_dur_clear[g] <= 1'b1;
                end
                if (!unlim_w[g]) begin
                  if (cnt_r[g] == swar_pkg::CNT_MAX) begin
                    rfull_r[g] <= 1'b1;
                  end else begin
                    cnt_r[g] <= cnt_r[g] + 4'h1;
                  end
                end
              end
            end
            swar_pkg::ST_LATCHED: begin
              tmr_r[g] <= 18'h00000;
              if (delatch_req[g]) begin
                state_r[g] <= swar_pkg::ST_NORMAL;
              end else if (unl_rise_w[g] && ret_en_w[g]) begin
                state_r[g] <= swar_pkg::ST_WAIT;
              end else if (unl_rise_w[g]) begin
                state_r[g] <= swar_pkg::ST_NORMAL;
              end
            end
            default: state_r[g] <= swar_pkg::ST_NORMAL;
          endcase
          // unlimited mode with retry enabled never stays latched
          if (unlim_w[g] && state_r[g] == swar_pkg::ST_LATCHED &&
              ret_en_w[g]) begin
            state_r[g] <= swar_pkg::ST_WAIT;
          end
          if (clr_cnt_w[g]) begin
            cnt_r[g]   <= 4'h0;
            rfull_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // fault registers: hardware set wins over clear-on-read
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 2; g++) begin : g_flt
      logic [7:0] set_w;
      assign set_w = {state_r[g] == swar_pkg::ST_LATCHED,
                      os_det_w[g], oloff_det_w[g], open_load_on_fault_det_w[g],
                      undervoltage_fault, overtemp_fault[g],
                      severe_short_fault[g], overcurrent_fault[g]};
      always_ff @(posedge core_clk) begin
        if (rst) begin
          fault_r[g] <= 8'h00;
        end else if (clk_en) begin
          // bits persist until read
          fault_r[g] <= (rd_flt_w[g] ? 8'h00 : fault_r[g]) | set_w;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // read mux; counter field only in normal mode
  // ----------------------------------------------------------------
  logic [15:0] rd_w;
  assign rd_w =
    reg_addr == swar_pkg::ADDR_RETRY0 ? {8'h00,
      (normal_mode ? cnt_r[0] : 4'h0), retry_r[0][3:0]} :
    reg_addr == swar_pkg::ADDR_RETRY1 ? {8'h00,
      (normal_mode ? cnt_r[1] : 4'h0), retry_r[1][3:0]} :
    reg_addr == swar_pkg::ADDR_CONFIG0 ? config_r[0] :
    reg_addr == swar_pkg::ADDR_CONFIG1 ? config_r[1] :
    reg_addr == swar_pkg::ADDR_FAULT0  ? {8'h00, fault_r[0]} :
    reg_addr == swar_pkg::ADDR_FAULT1  ? {8'h00, fault_r[1]} :
    reg_addr == swar_pkg::ADDR_STATUS  ?
      {10'h000, rfull_r, 4'h0} : 16'h0000;
  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata   <= 16'h0000;
      channel_on  <= 2'h0;
      diag_active <= 2'h0;
      fault_out_n <= 1'b1;
    end else if (clk_en) begin
      reg_rdata   <= reg_rd ? rd_w : 16'h0000;
      channel_on  <= ch_live_w;
      diag_active <= {duty_pct <= duty_lim_w[1],
                      duty_pct <= duty_lim_w[0]};
      fault_out_n <= ~(live_w[0] | live_w[1]);
    end
  end
endmodule
`default_nettype wire

// file: swar_monitor.sv
// swar_monitor: concurrent checks on the retry and diagnostic ports
// assumes a bind into swar_top; one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module swar_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        normal_mode,
  input wire logic        undervoltage_fault,
  input wire logic [1:0]  channel_cmd_on,
  input wire logic [1:0]  overcurrent_fault,
  input wire logic [1:0]  severe_short_fault,
  input wire logic [1:0]  overtemp_fault,
  input wire logic [1:0]  direct_input,
  input wire logic [6:0]  duty_pct,
  input wire logic [1:0]  channel_on,
  input wire logic [1:0]  oc_dur_clear,
  input wire logic [1:0]  diag_active,
  input wire logic        fault_out_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // latchable cause on channel 0, or command dropped
  wire logic cause0 = overcurrent_fault[0] | severe_short_fault[0] |
                      overtemp_fault[0] | undervoltage_fault;
  wire logic drop0  = cause0 | ~channel_cmd_on[0];
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  sequence rd_hidden;
    clk_en && reg_rd && reg_addr == swar_pkg::ADDR_RETRY0 && !normal_mode;
  endsequence
  sequence bus_idle;
    clk_en && !reg_rd;
  endsequence
  cnt_hidden_a: assert property (rd_hidden |=> reg_rdata[7:4] == 4'h0)
    else $error("retry count visible outside normal mode");
  rdata_idle_a: assert property (bus_idle |=> reg_rdata == 16'h0000)
    else $error("read data present without a read");
  // ----------------------------------------------------------------
  // channel and diagnostic outputs
  // ----------------------------------------------------------------
  keep_on_a: assert property (clk_en && channel_on[0] && !drop0
    |=> channel_on[0]) else $error("channel off without a latchable cause");
  fall_cause_a: assert property ($fell(channel_on[0])
    |-> $past(drop0) || $past(drop0, 2)) else $error("turn-off without cause");
  rst_clear_a: assert property (disable iff (1'b0) rst
    |=> channel_on == 2'b00 && fault_out_n) else $error("reset state wrong");
  diag_over_a: assert property (clk_en && duty_pct > swar_pkg::DUTY_LIM_NORM
    |=> !diag_active[0]) else $error("diagnostics above duty limit");
  diag_under_a: assert property (clk_en && !direct_input[0]
    && duty_pct <= swar_pkg::DUTY_LIM_NORM |=> diag_active[0])
    else $error("diagnostics missing within duty limit");
  clr_pulse_a: assert property (clk_en && oc_dur_clear[0]
    |=> !oc_dur_clear[0]) else $error("duration clear longer than a cycle");
endmodule
bind swar_top swar_monitor u_mon (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .normal_mode(normal_mode),
  .undervoltage_fault(undervoltage_fault), .channel_cmd_on(channel_cmd_on),
  .overcurrent_fault(overcurrent_fault), .duty_pct(duty_pct),
  .severe_short_fault(severe_short_fault), .overtemp_fault(overtemp_fault),
  .direct_input(direct_input), .channel_on(channel_on),
  .oc_dur_clear(oc_dur_clear), .diag_active(diag_active),
  .fault_out_n(fault_out_n));
`default_nettype wire

// file: swar_host.sv
// swar_host: host model driving the register port and delatch requests
// assumes strobes are sampled on the rising edge, read data one cycle on
`timescale 1ns/1ps
`default_nettype none
module swar_host (
  input  wire logic        core_clk,
  output var  logic [3:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  input  wire logic [15:0] reg_rdata,
  output var  logic [1:0]  delatch_req
);
  // idle bus from time zero
  initial {reg_addr, reg_wdata, reg_wr, reg_rd, delatch_req} = '0;
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data is taken after the strobe edge's updates have landed
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // host delatch sequence, one pulse on the chosen channel
  task automatic delatch(input int ch);
    @(posedge core_clk);
    delatch_req[ch] <= 1'b1;
    @(posedge core_clk);
    delatch_req[ch] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: swar_top_test.sv
// swar_top_test: self-checking bench for the retry and diagnostic block
// assumes swar_host drives the register port and swar_monitor is bound
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module swar_top_test;
  logic        core_clk, rst, normal_mode, undervoltage_fault, fault_out_n;
  logic [1:0]  application_type_pin, fault_control_signal, overcurrent_fault;
  logic [1:0]  severe_short_fault, overtemp_fault, open_load_off_fault;
  logic [1:0]  short_to_supply_fault, channel_cmd_on, direct_input;
  logic [1:0]  low_current_sense_ratio, delatch_req, channel_on;
  logic [1:0]  oc_dur_clear, diag_active, open_load_on_fault;
  logic [6:0]  duty_pct;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic        reg_wr, reg_rd;
  int          n_mismatch = 0;
  int          n_compared = 0;
  // dut; sleep, fail-safe and period hint idle
  swar_top u_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .normal_mode(normal_mode),
    .failsafe_enter(1'b0), .sleep_exit(1'b0),
    .undervoltage_fault(undervoltage_fault),
    .application_type_pin(application_type_pin),
    .fault_control_signal(fault_control_signal),
    .overcurrent_fault(overcurrent_fault),
    .severe_short_fault(severe_short_fault), .overtemp_fault(overtemp_fault),
    .open_load_on_fault(open_load_on_fault),
    .open_load_off_fault(open_load_off_fault),
    .short_to_supply_fault(short_to_supply_fault),
    .channel_cmd_on(channel_cmd_on), .delatch_req(delatch_req),
    .period_end(2'b00), .direct_input(direct_input),
    .low_current_sense_ratio(low_current_sense_ratio), .duty_pct(duty_pct),
    .channel_on(channel_on), .oc_dur_clear(oc_dur_clear),
    .diag_active(diag_active), .fault_out_n(fault_out_n));
  swar_host u_host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .delatch_req(delatch_req));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [15:0] ex,
                        input string nm);
    u_host.rd(a, rd_val);
    `CHK(nm, ex, rd_val)
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    for (int i = 0; i < 7; i++) chk_rd(4'(i), 16'h0000, "reset value");
    u_host.wr(4'hf, 16'hffff);
    chk_rd(4'hf, 16'h0000, "unmapped");
    u_host.wr(swar_pkg::ADDR_RETRY0, 16'hffff);
    chk_rd(swar_pkg::ADDR_RETRY0, 16'h000f, "retry fields");
    u_host.wr(swar_pkg::ADDR_RETRY0, 16'h0000);
    $display("test regs done");
  endtask
  // duty limit 90, or 85 with direct input and low ratio
  task automatic test_window();
    logic [6:0] duty [5] = '{7'h50, 7'h5a, 7'h5b, 7'h55, 7'h56};
    logic [4:0] expv = 5'b01011;
    for (int k = 0; k < 5; k++) begin
      direct_input <= {1'b0, k > 2};
      low_current_sense_ratio <= {1'b0, k > 2};
      duty_pct <= duty[k];
      idle(3);
      `CHK("diag window", expv[k], diag_active[0])
    end
    $display("test window done");
  endtask
  // k 0 short to supply on bit 6, k 1 off-state open load on bit 5
  task automatic test_diag();
    for (int k = 0; k < 2; k++) begin
      short_to_supply_fault <= {1'b0, k == 0};
      open_load_off_fault <= {1'b0, k == 1};
      idle(3);
      `CHK("fault out live", 1'b0, fault_out_n)
      short_to_supply_fault <= 2'b00;
      open_load_off_fault <= 2'b00;
      idle(3);
      `CHK("fault out gone", 1'b1, fault_out_n)
      chk_rd(swar_pkg::ADDR_FAULT0, 16'h0040 >> k, "sticky bit");
      chk_rd(swar_pkg::ADDR_FAULT0, 16'h0000, "read clear");
      u_host.wr(swar_pkg::ADDR_CONFIG0, 16'h0040 << k);
      short_to_supply_fault <= {1'b0, k == 0};
      open_load_off_fault <= {1'b0, k == 1};
      idle(3);
      short_to_supply_fault <= 2'b00;
      open_load_off_fault <= 2'b00;
      chk_rd(swar_pkg::ADDR_FAULT0, 16'h0000, "disabled bit");
      u_host.wr(swar_pkg::ADDR_CONFIG0, 16'h0000);
    end
    $display("test diag done");
  endtask
  // lamp channel 0, retry enabled, shortest period
  task automatic test_retry();
    int   n = 3;
    logic saw = 1'b0;
    channel_cmd_on <= 2'b01;
    idle(3);
    overcurrent_fault <= 2'b01;
    idle(3);
    overcurrent_fault <= 2'b00;
    while (channel_on[0] !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
      if (oc_dur_clear[0] === 1'b1) saw = 1'b1;
    end
    repeat (3) begin
      @(posedge core_clk);
      if (oc_dur_clear[0] === 1'b1) saw = 1'b1;
    end
    `CHK("period", 1'b1, n >= swar_pkg::CYC_AUTO0 - 3)
    `CHK("period end", 1'b1, n <= swar_pkg::CYC_AUTO0 + 6)
    `CHK("duration clear", 1'b1, saw)
    `CHK("fault out", 1'b1, fault_out_n)
    chk_rd(swar_pkg::ADDR_RETRY0, 16'h0010, "count");
    chk_rd(swar_pkg::ADDR_FAULT0, 16'h0001, "fault kept");
    normal_mode <= 1'b0;
    chk_rd(swar_pkg::ADDR_RETRY0, 16'h0000, "count hidden");
    normal_mode <= 1'b1;
    u_host.wr(swar_pkg::ADDR_RETRY0, 16'h0002);
    chk_rd(swar_pkg::ADDR_RETRY0, 16'h0002, "count cleared");
    $display("test retry done");
  endtask
  // motor channel 1, select 0: retry off, latches at once
  task automatic test_latch();
    application_type_pin <= 2'b10;
    channel_cmd_on <= 2'b11;
    idle(3);
    severe_short_fault <= 2'b10;
    overtemp_fault <= 2'b10;
    idle(3);
    severe_short_fault <= 2'b00;
    overtemp_fault <= 2'b00;
    idle(20);
    `CHK("latched off", 1'b0, channel_on[1])
    `CHK("latched out", 1'b0, fault_out_n)
    u_host.delatch(1);
    idle(3);
    `CHK("delatched on", 1'b1, channel_on[1])
    $display("test latch done");
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    rst = 1'b1;
    normal_mode = 1'b1;
    fault_control_signal = 2'b11;
    {undervoltage_fault, application_type_pin, overcurrent_fault,
     severe_short_fault, overtemp_fault, open_load_on_fault,
     open_load_off_fault, short_to_supply_fault, channel_cmd_on,
     direct_input, low_current_sense_ratio} = '0;
    duty_pct = 7'h50;
    idle(6);
    rst <= 1'b0;
    idle(1);
    test_regs();
    test_window();
    test_diag();
    test_retry();
    test_latch();
    finish_test();
  end
endmodule
`default_nettype wire
